// [rtl/srlr_consts.svh]
// constants of the supply range and lifetime resource responder
// assumes inclusion by bare name from the design and sim files
`ifndef SRLR_CONSTS_SVH
`define SRLR_CONSTS_SVH

// apb byte offsets
`define SRLR_OFF_REQ 8'h00
`define SRLR_OFF_IDENT 8'h04
`define SRLR_OFF_CMD 8'h08
`define SRLR_OFF_STATUS 8'h0C
`define SRLR_OFF_RESP_HI 8'h10
`define SRLR_OFF_RESP_LO 8'h14
`define SRLR_OFF_LIFE 8'h18

// request, command and status register field positions
`define SRLR_REQ_OFFSET_MSB 14
`define SRLR_REQ_LEN_LSB 16
`define SRLR_REQ_LEN_MSB 19
`define SRLR_REQ_WRITE_BIT 20
`define SRLR_REQ_INDIRECT_BIT 21
`define SRLR_CMD_GO_BIT 0
`define SRLR_STATUS_DONE_BIT 0

// resource identifiers
`define SRLR_IDENT_SUPPLY 12'h2C4
`define SRLR_IDENT_LIFETIME 12'h2CB

// supply limits in millivolts
`define SRLR_SUPPLY_MIN_MV 16'h1B58
`define SRLR_SUPPLY_MAX_MV 16'h2EE0
`define SRLR_SUPPLY_LIMIT_MV 16'h3A98

// error code pairs
`define SRLR_ERR_RD_HI 8'h13
`define SRLR_ERR_RD_LO 8'h40
`define SRLR_ERR_DWR_HI 8'h14
`define SRLR_ERR_DWR_LO 8'h41
`define SRLR_ERR_IWR_HI 8'h10
`define SRLR_ERR_IWR_LO 8'h41

// definition qualifiers
`define SRLR_QIDX_LAST 15'h0005
`define SRLR_Q_NAME_SUPPLY 64'h5348_5F53_5550_5200
`define SRLR_Q_NAME_LIFE 64'h5348_5F4C_4946_4554
`define SRLR_Q_SIZE 16'h0004
`define SRLR_Q_RD_LEVEL 16'h0000
`define SRLR_Q_WR_LEVEL 16'h000F
`define SRLR_Q_TMO_SUPPLY 16'h0012
`define SRLR_Q_TMO_LIFE 16'h0007
`define SRLR_Q_TYPE_U16 16'h0004
`define SRLR_Q_TYPE_U32 16'h0005
`define SRLR_LEN_NAME 4'h8
`define SRLR_LEN_WORD 4'h2
`define SRLR_LEN_DWORD 4'h4
`define SRLR_LEN_NONE 4'h0

// timing
`define SRLR_CLK_HZ 250000000
`define SRLR_MINUTE_S 60

`endif

// [rtl/srlr_minute_counter.sv]
// saturating operating time counter in whole minutes
// assumes a free running clock while powered
`timescale 1ns/1ns
`default_nettype none
`include "srlr_consts.svh"
module srlr_minute_counter #(
   parameter logic [35:0] MINUTE_CYCLES = 36'h3_7E11_D600
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic [31:0] minutes
);
   srlr_pkg::srlr_count_t cur;
   srlr_pkg::srlr_count_t next_cur;

   always_comb begin
      next_cur = cur;
      if (cur.presc >= MINUTE_CYCLES - 36'h0_0000_0001) begin
         next_cur.presc = 36'h0_0000_0000;
         if (cur.minutes != 32'hFFFF_FFFF) begin
            next_cur.minutes = cur.minutes + 32'h0000_0001;
         end
      end else begin
         next_cur.presc = cur.presc + 36'h0_0000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign minutes = cur.minutes;
endmodule
`default_nettype wire

// [rtl/srlr_pkg.sv]
// types of the supply range and lifetime resource responder
// assumes srlr_consts.svh on the include path
`default_nettype none
package srlr_pkg;
   typedef enum logic {
      SRLR_ST_IDLE,
      SRLR_ST_EXEC
   } srlr_state_t;

   typedef struct packed {
      logic [11:0] resource_identifier;
      logic indirect;
      logic write;
      logic [3:0] len;
      logic [14:0] offset;
   } srlr_req_t;

   typedef struct packed {
      srlr_state_t state;
      srlr_req_t req;
      logic done;
      logic error;
      logic [3:0] resp_len;
      logic [7:0] err_hi;
      logic [7:0] err_lo;
      logic [63:0] resp;
      logic [31:0] prdata;
      logic pslverr;
   } srlr_main_t;

   typedef struct packed {
      logic [35:0] presc;
      logic [31:0] minutes;
   } srlr_count_t;
endpackage
`default_nettype wire

// [rtl/srlr_qual_if.sv]
// carrier between the responder and its qualifier table
// assumes both ends in the same clock domain
`timescale 1ns/1ns
`default_nettype none
interface srlr_qual_if;
   logic lifetime_sel;
   logic [2:0] index;
   logic [63:0] bytes;
   logic [3:0] len;
   modport table_end (
      input lifetime_sel,
      input index,
      output bytes,
      output len
   );
   modport user_end (
      output lifetime_sel,
      output index,
      input bytes,
      input len
   );
endinterface
`default_nettype wire

// [rtl/srlr_qualifier_table.sv]
// resource definition qualifiers of both resources
// assumes index already checked against the last qualifier
`timescale 1ns/1ns
`default_nettype none
`include "srlr_consts.svh"
module srlr_qualifier_table (
   srlr_qual_if.table_end q
);
   logic [15:0] word;

   always_comb begin
      word = `SRLR_Q_RD_LEVEL;
      q.bytes = 64'h0000_0000_0000_0000;
      q.len = `SRLR_LEN_WORD;
      case (q.index)
         3'h0: begin
            q.bytes = q.lifetime_sel ? `SRLR_Q_NAME_LIFE : `SRLR_Q_NAME_SUPPLY;
            q.len = `SRLR_LEN_NAME;
         end
         3'h1: word = `SRLR_Q_SIZE;
         3'h2: word = `SRLR_Q_RD_LEVEL;
         3'h3: word = `SRLR_Q_WR_LEVEL;
         3'h4: word = q.lifetime_sel ? `SRLR_Q_TMO_LIFE : `SRLR_Q_TMO_SUPPLY;
         3'h5: word = q.lifetime_sel ? `SRLR_Q_TYPE_U32 : `SRLR_Q_TYPE_U16;
         default: q.len = `SRLR_LEN_NONE;
      endcase
      if (q.index != 3'h0) begin
         q.bytes = {word, 48'h0000_0000_0000};
      end
   end
endmodule
`default_nettype wire

// [rtl/srlr_responder.sv]
// apb reachable responder for the supply range and lifetime resources
// assumes an apb master on pclk and a transport that copies requests in
`timescale 1ns/1ns
`default_nettype none
`include "srlr_consts.svh"
module srlr_responder #(
   parameter logic [35:0] MINUTE_CYCLES = 36'(64'(`SRLR_MINUTE_S) * 64'(`SRLR_CLK_HZ))
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   srlr_pkg::srlr_main_t cur;
   srlr_pkg::srlr_main_t next_cur;
   logic [31:0] minutes;
   logic [15:0] supply_min;
   logic [15:0] supply_max;
   logic is_supply;
   logic is_life;
   logic wr_access;
   logic go;
   logic done_clr;
   logic done_set;
   logic [31:0] status_word;

   srlr_qual_if qif();

   srlr_qualifier_table u_table (
      .q(qif.table_end)
   );

   srlr_minute_counter #(
      .MINUTE_CYCLES(MINUTE_CYCLES)
   ) u_minutes (
      .pclk(pclk),
      .presetn(presetn),
      .minutes(minutes)
   );

   assign supply_min = (`SRLR_SUPPLY_MIN_MV > `SRLR_SUPPLY_LIMIT_MV) ? `SRLR_SUPPLY_LIMIT_MV : `SRLR_SUPPLY_MIN_MV;
   assign supply_max = (`SRLR_SUPPLY_MAX_MV > `SRLR_SUPPLY_LIMIT_MV) ? `SRLR_SUPPLY_LIMIT_MV : `SRLR_SUPPLY_MAX_MV;

   assign is_supply = (cur.req.resource_identifier == `SRLR_IDENT_SUPPLY);
   assign is_life = (cur.req.resource_identifier == `SRLR_IDENT_LIFETIME);
   assign qif.lifetime_sel = is_life;
   assign qif.index = cur.req.offset[2:0];

   assign wr_access = psel & penable & pwrite & ~cur.pslverr;
   assign go = wr_access & (paddr == `SRLR_OFF_CMD) & pwdata[`SRLR_CMD_GO_BIT] & (cur.state == srlr_pkg::SRLR_ST_IDLE);
   assign done_clr = wr_access & (paddr == `SRLR_OFF_STATUS) & pwdata[`SRLR_STATUS_DONE_BIT];
   assign done_set = (cur.state == srlr_pkg::SRLR_ST_EXEC);

   assign status_word = {8'h00, cur.err_lo, cur.err_hi, cur.resp_len, 1'b0,
                         cur.state == srlr_pkg::SRLR_ST_EXEC, cur.error, cur.done};

   always_comb begin
      next_cur = cur;

      // apb read capture in setup phase
      if (psel & ~penable) begin
         next_cur.pslverr = 1'b0;
         case (paddr)
            `SRLR_OFF_REQ: next_cur.prdata = {10'h000, cur.req.indirect, cur.req.write,
                                              cur.req.len, 1'b0, cur.req.offset};
            `SRLR_OFF_IDENT: next_cur.prdata = {20'h0_0000, cur.req.resource_identifier};
            `SRLR_OFF_CMD: next_cur.prdata = 32'h0000_0000;
            `SRLR_OFF_STATUS: next_cur.prdata = status_word;
            `SRLR_OFF_RESP_HI: next_cur.prdata = cur.resp[63:32];
            `SRLR_OFF_RESP_LO: next_cur.prdata = cur.resp[31:0];
            `SRLR_OFF_LIFE: next_cur.prdata = minutes;
            default: begin
               next_cur.prdata = 32'h0000_0000;
               next_cur.pslverr = 1'b1;
            end
         endcase
      end

      // request registers, frozen while executing
      if (wr_access & (cur.state == srlr_pkg::SRLR_ST_IDLE)) begin
         if (paddr == `SRLR_OFF_REQ) begin
            next_cur.req.offset = pwdata[`SRLR_REQ_OFFSET_MSB:0];
            next_cur.req.len = pwdata[`SRLR_REQ_LEN_MSB:`SRLR_REQ_LEN_LSB];
            next_cur.req.write = pwdata[`SRLR_REQ_WRITE_BIT];
            next_cur.req.indirect = pwdata[`SRLR_REQ_INDIRECT_BIT];
         end
         if (paddr == `SRLR_OFF_IDENT) begin
            next_cur.req.resource_identifier = pwdata[11:0];
         end
      end

      // done flag, set wins over clear
      next_cur.done = done_set | (cur.done & ~done_clr);

      case (cur.state)
         srlr_pkg::SRLR_ST_IDLE: begin
            if (go) begin
               next_cur.state = srlr_pkg::SRLR_ST_EXEC;
               next_cur.done = 1'b0;
            end
         end
         srlr_pkg::SRLR_ST_EXEC: begin
            next_cur.state = srlr_pkg::SRLR_ST_IDLE;
            next_cur.error = 1'b1;
            next_cur.resp = 64'h0000_0000_0000_0000;
            next_cur.resp_len = `SRLR_LEN_NONE;
            next_cur.err_hi = `SRLR_ERR_RD_HI;
            next_cur.err_lo = `SRLR_ERR_RD_LO;
            if (!(is_supply | is_life)) begin
               next_cur.error = 1'b1;
            end else if (!cur.req.indirect && cur.req.write) begin
               next_cur.err_hi = `SRLR_ERR_DWR_HI;
               next_cur.err_lo = `SRLR_ERR_DWR_LO;
            end else if (!cur.req.indirect) begin
               if (cur.req.offset <= `SRLR_QIDX_LAST) begin
                  next_cur.error = 1'b0;
                  next_cur.resp = qif.bytes;
                  next_cur.resp_len = qif.len;
                  next_cur.err_hi = 8'h00;
                  next_cur.err_lo = 8'h00;
               end
            end else if (cur.req.write) begin
               next_cur.err_hi = `SRLR_ERR_IWR_HI;
               next_cur.err_lo = `SRLR_ERR_IWR_LO;
            end else if (is_supply) begin
               if (cur.req.offset == 15'h0000 && cur.req.len == `SRLR_LEN_DWORD) begin
                  next_cur.error = 1'b0;
                  next_cur.resp = {supply_min, supply_max, 32'h0000_0000};
                  next_cur.resp_len = `SRLR_LEN_DWORD;
               end else if (cur.req.offset == 15'h0000 && cur.req.len == `SRLR_LEN_WORD) begin
                  next_cur.error = 1'b0;
                  next_cur.resp = {supply_min, 48'h0000_0000_0000};
                  next_cur.resp_len = `SRLR_LEN_WORD;
               end else if (cur.req.offset == 15'h0002 && cur.req.len == `SRLR_LEN_WORD) begin
                  next_cur.error = 1'b0;
                  next_cur.resp = {supply_max, 48'h0000_0000_0000};
                  next_cur.resp_len = `SRLR_LEN_WORD;
               end
               if (!next_cur.error) begin
                  next_cur.err_hi = 8'h00;
                  next_cur.err_lo = 8'h00;
               end
            end else begin
               if (cur.req.offset == 15'h0000 && cur.req.len == `SRLR_LEN_DWORD) begin
                  next_cur.error = 1'b0;
                  next_cur.resp = {minutes, 32'h0000_0000};
                  next_cur.resp_len = `SRLR_LEN_DWORD;
                  next_cur.err_hi = 8'h00;
                  next_cur.err_lo = 8'h00;
               end
            end
         end
         default: next_cur.state = srlr_pkg::SRLR_ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign prdata = cur.prdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & cur.pslverr;
endmodule
`default_nettype wire

// [sim/srlr_apb_host.sv]
// apb master standing in for the long message transport
// assumes a responder answering with pready on pclk
`timescale 1ns/1ns
`default_nettype none
module srlr_apb_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
         output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// [sim/srlr_responder_checker.sv]
// port assertions of the resource responder
// assumes binding onto srlr_responder
`timescale 1ns/1ns
`default_nettype none
`include "srlr_consts.svh"
module srlr_responder_checker #(
   parameter logic [35:0] MINUTE_CYCLES = 36'h0_0000_000A
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic acc;
   logic mapped;
   logic [31:0] last_life;
   assign acc = psel && penable;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         last_life <= 32'h0000_0000;
      else if (acc && !pwrite && paddr == `SRLR_OFF_LIFE)
         last_life <= prdata;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_go;
      acc && pwrite && paddr == `SRLR_OFF_CMD && pwdata[0];
   endsequence
   sequence s_status_rd;
      acc && !pwrite && paddr == `SRLR_OFF_STATUS;
   endsequence
   a_ready_high: assert property (pready) else $error("pready low");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
   a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("error on mapped place");
   a_idle_noerr: assert property (!acc |-> !pslverr) else $error("error outside access");
   a_unmapped_zero: assert property (acc && !mapped && !pwrite |-> prdata == 32'h0) else $error("data on unmapped");
   a_cmd_reads_zero: assert property (acc && !pwrite && paddr == `SRLR_OFF_CMD |-> prdata == 32'h0) else $error("cmd read");
   a_life_monotonic: assert property (acc && !pwrite && paddr == `SRLR_OFF_LIFE |-> prdata >= last_life)
      else $error("minutes went back");
   a_done_after_go: assert property (s_go ##3 s_status_rd |-> prdata[0] && !prdata[2])
      else $error("result late");
endmodule
bind srlr_responder srlr_responder_checker #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [sim/srlr_responder_tb.sv]
// self checking bench of the resource responder
// assumes the host model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "srlr_consts.svh"
module srlr_responder_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int err_total = 0;
   int samples_checked = 0;
   int seed = 32'h9099;
   int cyc = 0;
   always #2 pclk = ~pclk;
   always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;
   srlr_responder #(.MINUTE_CYCLES(36'h0_0000_000A)) u_srlr_responder (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   srlr_apb_host u_srlr_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task automatic check(input string nm, input logic [83:0] exp, input logic [83:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      u_srlr_apb_host.xfer(w, a, d, r, er);
   endtask
   function automatic logic [83:0] expect_of(input logic [11:0] ident, input logic ind, input logic wr,
         input logic [3:0] len, input logic [14:0] off);
      logic sup;
      logic [15:0] q;
      sup = ident == `SRLR_IDENT_SUPPLY;
      if (!sup && ident != `SRLR_IDENT_LIFETIME)
         return {16'h1340, 68'h0};
      if (wr)
         return {ind ? 16'h1041 : 16'h1441, 68'h0};
      if (!ind) begin
         if (off > 15'd5)
            return {16'h1340, 68'h0};
         if (off == 15'd0)
            return {20'h0_0008, sup ? `SRLR_Q_NAME_SUPPLY : `SRLR_Q_NAME_LIFE};
         q = off == 1 ? 16'h0004 : off == 2 ? 16'h0000 : off == 3 ? 16'h000F : off == 4 ?
            (sup ? 16'h0012 : 16'h0007) : (sup ? 16'h0004 : 16'h0005);
         return {20'h0_0002, q, 48'h0};
      end
      if (sup && off == 0 && len == 4)
         return {20'h0_0004, 64'h1B58_2EE0_0000_0000};
      if (sup && len == 2 && (off == 0 || off == 2))
         return {20'h0_0002, off == 0 ? 16'h1B58 : 16'h2EE0, 48'h0};
      if (!sup && off == 0 && len == 4)
         return {20'h0_0004, 64'h0};
      return {16'h1340, 68'h0};
   endfunction
   task automatic run(input logic [11:0] ident, input logic ind, input logic wr, input logic [3:0] len,
         input logic [14:0] off);
      logic [83:0] x;
      logic [31:0] st, hi, lo, m;
      x = expect_of(ident, ind, wr, len, off);
      bus(1'b1, `SRLR_OFF_IDENT, {20'h0, ident}, st);
      bus(1'b1, `SRLR_OFF_REQ, {10'h0, ind, wr, len, 1'b0, off}, st);
      bus(1'b1, `SRLR_OFF_CMD, 32'h1, st);
      st = 32'h0;
      for (int n = 0; n < 8 && st[0] !== 1'b1; n++)
         bus(1'b0, `SRLR_OFF_STATUS, 32'h0, st);
      bus(1'b0, `SRLR_OFF_RESP_HI, 32'h0, hi);
      bus(1'b0, `SRLR_OFF_RESP_LO, 32'h0, lo);
      bus(1'b0, `SRLR_OFF_LIFE, 32'h0, m);
      check("status", {x[83:68], |x[83:68], 2'b01}, {st[15:8], st[23:16], st[1], st[2], st[0]});
      if (x[83:68] != 16'h0)
         return;
      if (ind && ident == `SRLR_IDENT_LIFETIME)
         check("minutes", 1'b1, (m - hi) <= 32'd1 && st[7:4] == 4'h4 && lo == 32'h0);
      else
         check("resp", x[67:0], {st[7:4], hi, lo});
   endtask
   initial begin
      #100000;
      err_total++;
      stop_test();
   end
   initial begin
      logic [31:0] r;
      logic [3:0] ln;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 14; i++)
         run(i < 7 ? `SRLR_IDENT_SUPPLY : `SRLR_IDENT_LIFETIME, 0, 0, i % 7 == 0 ? 4'h8 : 4'h2, 15'(i % 7));
      run(`SRLR_IDENT_SUPPLY, 1, 0, 4'h4, 15'h0);
      run(`SRLR_IDENT_SUPPLY, 1, 0, 4'h2, 15'h0);
      run(`SRLR_IDENT_SUPPLY, 1, 0, 4'h2, 15'h2);
      run(`SRLR_IDENT_SUPPLY, 1, 0, 4'h8, 15'h8);
      run(`SRLR_IDENT_LIFETIME, 1, 0, 4'h4, 15'h0);
      run(`SRLR_IDENT_LIFETIME, 1, 0, 4'h4, 15'h4);
      run(`SRLR_IDENT_SUPPLY, 0, 1, 4'h2, 15'h7FFF);
      run(`SRLR_IDENT_LIFETIME, 1, 1, 4'h4, 15'h0);
      run(`SRLR_IDENT_SUPPLY, 0, 0, 4'h2, 15'h7FFF);
      run(12'h123, 0, 1, 4'h2, 15'h0000);
      for (int i = 0; i < 24; i++) begin
         r = $random(seed);
         ln = r[5:4] == 2'd0 ? 4'h2 : r[5:4] == 2'd1 ? 4'h4 : 4'h8;
         if (!r[2] && !r[3])
            ln = r[9:7] == 3'd0 ? 4'h8 : 4'h2;
         run(r[0] ? `SRLR_IDENT_SUPPLY : r[1] ? `SRLR_IDENT_LIFETIME : r[27:16], r[2], r[3], ln,
            r[6] ? r[30:16] : 15'(r[9:7]));
      end
      bus(1'b0, 8'h1C, 32'h0, rd);
      check("unmapped", {1'b1, 32'h0}, {er, rd});
      bus(1'b0, 8'h02, 32'h0, rd);
      check("unaligned", {1'b1, 32'h0}, {er, rd});
      bus(1'b1, `SRLR_OFF_REQ, 32'hFFE3_FFFF, rd);
      bus(1'b0, `SRLR_OFF_REQ, 32'h0, rd);
      check("request readback", {1'b0, 32'h0023_7FFF}, {er, rd});
      bus(1'b1, `SRLR_OFF_IDENT, 32'hFFFF_F2CB, rd);
      bus(1'b0, `SRLR_OFF_IDENT, 32'h0, rd);
      check("identifier readback", {1'b0, 32'h0000_02CB}, {er, rd});
      bus(1'b0, `SRLR_OFF_CMD, 32'h0, rd);
      check("command read", {1'b0, 32'h0}, {er, rd});
      bus(1'b1, `SRLR_OFF_STATUS, 32'h1, rd);
      bus(1'b0, `SRLR_OFF_STATUS, 32'h0, rd);
      check("done clear", 1'b0, rd[0]);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (95) @(posedge pclk);
      bus(1'b0, `SRLR_OFF_LIFE, 32'h0, rd);
      check("minute rate", 1'b1, (cyc / 10 - int'(rd)) inside {[-2:2]});
      stop_test();
   end
endmodule
`default_nettype wire
